// ### pkg/trace_params.svh
/*
 Register offsets, field positions, reset values and compare-field masks
 of the bus trace event comparator.
 Assumes a 12-bit AXI4-Lite byte address and 32-bit data.
*/
`ifndef TRACE_PARAMS_SVH
`define TRACE_PARAMS_SVH
// ==========================================================
// Register offsets
`define TR_CTRL 12'h000
`define TR_STATUS 12'h004
`define TR_TRIG_DELAY 12'h008
`define TR_FILT_DELAY 12'h00c
`define TR_PRESCALE 12'h010
`define TR_LOOP_LOAD 12'h014
`define TR_EV_ACTIVE 12'h018
`define TR_ROW_EN 12'h01c
`define TR_SETCLR 12'h020
`define TR_FRAMES 12'h024
`define TR_LOOP_CNT 12'h028
`define TR_CYCLES 12'h02c
`define TR_TIME 12'h030
`define TR_EXPR_PAGE 6'h01
`define TR_EXPR_NUM 14
`define TR_ROW_PAGE 4'h1
`define TR_BUF_PAGE 2'h1
// ==========================================================
// Field positions
`define TR_CTRL_START 0
`define TR_CTRL_STOP 1
`define TR_CTRL_PROBE 2
`define TR_EXPR_TRIG 0
`define TR_EXPR_REC 1
`define TR_EXPR_SET0 2
`define TR_EXPR_CLR0 8
`define TR_S_LOOP 3
`define TR_S_POD 4
`define TR_S_CYCLE 5
// ==========================================================
// Reset values and codes
`define TR_EXPR_FALSE 32'h8000_0000
`define TR_EXPR_TRUE 32'h0000_0000
`define TR_TRIG_DELAY_RST 16'h8000
`define TR_PROBE_RST 1'b1
`define TR_RESP_OKAY 2'b00
`define TR_RESP_SLVERR 2'b10
// ==========================================================
// Compare-field masks over the 48-bit frame
`define TR_MASK_ADDR 48'h0000_0000_ffff
`define TR_MASK_MISC 48'h0000_00ff_0000
`define TR_MASK_DATA 48'h0000_ff00_0000
`define TR_MASK_P1 48'h00ff_0000_0000
`define TR_MASK_P3 48'hff00_0000_0000
`endif

// ### pkg/trace_pkg.sv
/*
 Types of the bus trace event comparator: bus carriers, target pins,
 the compared frame and the expression word.
 Assumes nothing beyond a SystemVerilog tool.
*/
package trace_pkg;
    typedef struct packed {
        logic [11:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [11:0] araddr;
        logic arvalid;
        logic rready;
    } axi_lite_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axi_lite_rsp_t;
    typedef struct packed {
        logic address_latch_strobe;
        logic program_fetch_strobe_n;
        logic read_strobe_n;
        logic write_strobe_n;
        logic [7:0] ad_bus;
        logic [7:0] addr_high;
        logic [7:0] misc;
        logic [7:0] port_one_probes;
        logic [7:0] port_three_probes;
        logic external_probe_zero;
        logic external_probe_one;
    } target_pins_t;
    typedef struct packed {
        logic [7:0] port_three;
        logic [7:0] port_one;
        logic [7:0] data;
        logic [7:0] misc;
        logic [15:0] addr;
    } frame_t;
    typedef struct packed {
        logic invert;
        logic [14:0] need_false;
        logic spare;
        logic [14:0] need_true;
    } expr_t;
endpackage

// ### hdl/event_match.sv
/*
 One programmable event: five compare fields, each the OR of its enabled rows, and true when no row is enabled.
 Assumes a registered frame and registered compare rows from the top.
*/
`timescale 1ns/1ps
`include "trace_params.svh"
module event_match #(
    parameter int ROWS = 2
) (
    input trace_pkg::frame_t i_frame,
    input logic [ROWS-1:0][47:0] i_value,
    input logic [ROWS-1:0][47:0] i_care,
    input logic [ROWS-1:0] i_row_en,
    input logic i_active,
    output logic o_hit
);
    import trace_pkg::*;
    localparam logic [4:0][47:0] FIELD_MASK = {`TR_MASK_P3, `TR_MASK_P1,
        `TR_MASK_DATA, `TR_MASK_MISC, `TR_MASK_ADDR};
    logic [4:0] field_hit;
    // ==========================================================
    // Field compares
    genvar f;
    generate
        for (f = 0; f < 5; f++) begin : g_field
            logic hit;
            always_comb begin
                hit = ~(|i_row_en);
                for (int r = 0; r < ROWS; r++) begin
                    if (i_row_en[r] && (((i_frame ^ i_value[r]) & i_care[r]
                        & FIELD_MASK[f]) == 48'h0)) begin
                        hit = 1'b1;
                    end
                end
            end
            assign field_hit[f] = hit;
        end
    endgenerate
    assign o_hit = i_active & (&field_hit);
endmodule

// ### hdl/trace_capture_top.sv
/*
 Bus trace capture and event comparator with its AXI4-Lite register file.
 Assumes target strobes and probes arrive asynchronously on pins and that
 each strobe lasts several core clocks, so synchronised edges suffice.
*/
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "trace_params.svh"
module trace_capture_top #(
    parameter int ROWS = 2,
    parameter int DEPTH = 16
) (
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    input trace_pkg::target_pins_t I_TARGET_PINS,
    input trace_pkg::axi_lite_req_t I_AXI_REQ,
    output trace_pkg::axi_lite_rsp_t O_AXI_RSP,
    output logic O_SCOPE_OUTPUT_PIN_N
);
    import trace_pkg::*;
    localparam int PW = $clog2(DEPTH);
    localparam int RW = 8 * ROWS;

    // ==========================================================
    // Parameter check
    if (ROWS < 1 || ROWS > 2 || DEPTH < 2 || DEPTH > 128 ||
        (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
        $error("Unsupported ROWS or DEPTH");
    end

    // ==========================================================
    // State
    typedef struct packed {
        target_pins_t sync1;
        target_pins_t sync2;
        logic any_d;
        logic ale_d;
        logic [7:0] addr_lo;
        logic [7:0] addr_hi;
        logic [7:0] port3;
        frame_t frame;
        logic [15:0] frame_ts;
        logic eval;
        axi_lite_rsp_t rsp;
        logic aw_have;
        logic [11:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic probe_sel;
        logic [15:0] trig_delay;
        logic [15:0] filter_delay;
        logic [15:0] loop_load;
        logic [7:0] prescale;
        logic [7:0] ev_active;
        logic [7:0][ROWS-1:0] row_en;
        logic [5:0] setclr;
        logic [13:0][31:0] expr;
        logic [7:0][ROWS-1:0][47:0] val;
        logic [7:0][ROWS-1:0][47:0] care;
        logic running;
        logic triggered;
        logic ts_ovf;
        logic [15:0] post_cnt;
        logic [15:0] filt_cnt;
        logic [15:0] frames;
        logic [15:0] loop_cnt;
        logic [5:0] st;
        logic [31:0] cycles;
        logic [31:0] time_cnt;
        logic [7:0] pre_cnt;
        logic [15:0] ts;
        logic [PW-1:0] wr_ptr;
        logic [DEPTH-1:0][63:0] tbuf;
        logic scope_n;
    } state_t;

    function automatic state_t reset_state();
        state_t s;
        s = '0;
        s.sync1.program_fetch_strobe_n = 1'b1;
        s.sync1.read_strobe_n = 1'b1;
        s.sync1.write_strobe_n = 1'b1;
        s.sync2 = s.sync1;
        s.rsp.awready = 1'b1;
        s.rsp.wready = 1'b1;
        s.rsp.arready = 1'b1;
        s.probe_sel = `TR_PROBE_RST;
        s.trig_delay = `TR_TRIG_DELAY_RST;
        s.scope_n = 1'b1;
        for (int i = 0; i < `TR_EXPR_NUM; i++) begin
            s.expr[i] = (i == `TR_EXPR_REC) ? `TR_EXPR_TRUE : `TR_EXPR_FALSE;
        end
        return s;
    endfunction

    localparam state_t RST = reset_state();

    function automatic logic expr_eval(logic [31:0] r, logic [14:0] v);
        expr_t e;
        e = expr_t'(r);
        return e.invert ^ (((v & e.need_true) == e.need_true) &&
            ((~v & e.need_false) == e.need_false));
    endfunction

    function automatic logic [31:0] merge(logic [31:0] old,
        logic [31:0] nw, logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    state_t q;
    state_t d;
    target_pins_t p;
    logic any_now, lead, trail, ale_fall, tick, ovf_now;
    logic trig_x, rec_x, store, wr_go, wr_ok, rd_ok, start_cmd, stop_cmd;
    logic [7:0] ev_hit;
    logic [5:0] set_x, clr_x, ns;
    logic [14:0] in_vec;
    logic [11:0] wa, ra;
    logic [31:0] wd, rd_data;
    logic [3:0] ws;

    // ==========================================================
    // Events
    genvar e;
    generate
        for (e = 0; e < 8; e++) begin : g_ev
            event_match #(.ROWS(ROWS)) u_match (
                .i_frame(q.frame),
                .i_value(q.val[e]),
                .i_care(q.care[e]),
                .i_row_en(q.row_en[e]),
                .i_active(q.ev_active[e]),
                .o_hit(ev_hit[e])
            );
        end
    endgenerate

    // ==========================================================
    // Next state
    always_comb begin
        d = q;
        // Pin synchronisers and strobe edges
        d.sync1 = I_TARGET_PINS;
        d.sync2 = q.sync1;
        p = q.sync2;
        any_now = ~(p.program_fetch_strobe_n & p.read_strobe_n &
            p.write_strobe_n);
        lead = any_now & ~q.any_d;
        trail = ~any_now & q.any_d;
        ale_fall = ~p.address_latch_strobe & q.ale_d;
        d.any_d = any_now;
        d.ale_d = p.address_latch_strobe;
        d.eval = trail;
        if (ale_fall) begin
            d.addr_lo = p.ad_bus;
        end
        if (lead) begin
            d.addr_hi = p.addr_high;
            d.port3 = q.probe_sel ? {p.external_probe_one,
                p.external_probe_zero, p.port_three_probes[5:0]}
                : p.port_three_probes;
        end
        if (trail) begin
            d.frame.addr = {q.addr_hi, q.addr_lo};
            d.frame.port_three = q.port3;
            d.frame.port_one = p.port_one_probes;
            d.frame.data = p.ad_bus;
            d.frame.misc = p.misc;
            d.frame_ts = q.ts;
        end

        // Timestamp prescaler and execution time
        tick = (q.pre_cnt == q.prescale);
        d.pre_cnt = tick ? 8'h00 : q.pre_cnt + 8'h01;
        ovf_now = q.running & tick & (q.ts == 16'hffff);
        if (q.running && tick) begin
            d.ts = q.ts + 16'h0001;
        end
        if (ovf_now) begin
            d.ts_ovf = 1'b1;
        end
        if (q.st[`TR_S_CYCLE]) begin
            d.time_cnt = q.time_cnt + 32'h1;
        end

        // Expressions and state terms
        in_vec = {(q.loop_cnt == 16'h0), q.st, ev_hit};
        trig_x = expr_eval(q.expr[`TR_EXPR_TRIG], in_vec);
        rec_x = expr_eval(q.expr[`TR_EXPR_REC], in_vec);
        for (int i = 0; i < 6; i++) begin
            set_x[i] = expr_eval(q.expr[`TR_EXPR_SET0 + i], in_vec);
            clr_x[i] = expr_eval(q.expr[`TR_EXPR_CLR0 + i], in_vec);
            if (!q.setclr[i]) begin
                ns[i] = set_x[i];
            end else if (set_x[i]) begin
                ns[i] = 1'b1;
            end else if (clr_x[i]) begin
                ns[i] = 1'b0;
            end else begin
                ns[i] = q.st[i];
            end
        end
        store = 1'b0;
        if (q.eval) begin
            d.st = ns;
            if (ns[`TR_S_LOOP] && !q.st[`TR_S_LOOP] &&
                q.loop_cnt != 16'h0) begin
                d.loop_cnt = q.loop_cnt - 16'h0001;
            end
            if (q.st[`TR_S_CYCLE]) begin
                d.cycles = q.cycles + 32'h1;
            end
        end
        if (q.eval && q.running) begin
            if (q.triggered && q.post_cnt == 16'h0) begin
                d.running = 1'b0;
            end else begin
                store = rec_x | (q.filt_cnt != 16'h0);
                if (rec_x) begin
                    d.filt_cnt = q.filter_delay;
                end else if (q.filt_cnt != 16'h0) begin
                    d.filt_cnt = q.filt_cnt - 16'h0001;
                end
                if (q.triggered && store) begin
                    d.post_cnt = q.post_cnt - 16'h0001;
                end
                if (!q.triggered && trig_x) begin
                    d.triggered = 1'b1;
                    d.post_cnt = q.trig_delay;
                end
            end
        end
        if (store) begin
            d.tbuf[q.wr_ptr] = {q.frame_ts, q.frame};
            d.wr_ptr = q.wr_ptr + 1'b1;
            if (q.frames != 16'hffff) begin
                d.frames = q.frames + 16'h0001;
            end
        end

        // Write channels
        wa = q.aw_addr;
        wd = q.w_data;
        ws = q.w_strb;
        wr_ok = 1'b1;
        start_cmd = 1'b0;
        stop_cmd = 1'b0;
        if (q.rsp.bvalid && I_AXI_REQ.bready) begin
            d.rsp.bvalid = 1'b0;
        end
        wr_go = q.aw_have & q.w_have & ~q.rsp.bvalid;
        if (wr_go) begin
            if (wa[11:8] == `TR_ROW_PAGE) begin
                if (int'(wa[4]) < ROWS) begin
                    unique case (wa[3:2])
                        2'd0: d.val[wa[7:5]][wa[4]][31:0] =
                            merge(q.val[wa[7:5]][wa[4]][31:0], wd, ws);
                        2'd1: d.val[wa[7:5]][wa[4]][47:32] = 16'(merge(
                            {16'h0, q.val[wa[7:5]][wa[4]][47:32]}, wd, ws));
                        2'd2: d.care[wa[7:5]][wa[4]][31:0] =
                            merge(q.care[wa[7:5]][wa[4]][31:0], wd, ws);
                        2'd3: d.care[wa[7:5]][wa[4]][47:32] = 16'(merge(
                            {16'h0, q.care[wa[7:5]][wa[4]][47:32]}, wd, ws));
                    endcase
                end else begin
                    wr_ok = 1'b0;
                end
            end else if (wa[11:6] == `TR_EXPR_PAGE &&
                wa[5:2] < 4'(`TR_EXPR_NUM) && wa[1:0] == 2'h0) begin
                d.expr[wa[5:2]] = merge(q.expr[wa[5:2]], wd, ws);
            end else begin
                case (wa)
                    `TR_CTRL: begin
                        if (ws[0]) begin
                            start_cmd = wd[`TR_CTRL_START];
                            stop_cmd = wd[`TR_CTRL_STOP];
                            d.probe_sel = wd[`TR_CTRL_PROBE];
                        end
                    end
                    `TR_TRIG_DELAY: d.trig_delay =
                        16'(merge({16'h0, q.trig_delay}, wd, ws));
                    `TR_FILT_DELAY: d.filter_delay =
                        16'(merge({16'h0, q.filter_delay}, wd, ws));
                    `TR_LOOP_LOAD: d.loop_load =
                        16'(merge({16'h0, q.loop_load}, wd, ws));
                    `TR_PRESCALE: d.prescale =
                        8'(merge({24'h0, q.prescale}, wd, ws));
                    `TR_EV_ACTIVE: d.ev_active =
                        8'(merge({24'h0, q.ev_active}, wd, ws));
                    `TR_ROW_EN: d.row_en = RW'(merge(32'(q.row_en), wd, ws));
                    `TR_SETCLR: d.setclr =
                        6'(merge({26'h0, q.setclr}, wd, ws));
                    default: wr_ok = 1'b0;
                endcase
            end
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.rsp.bvalid = 1'b1;
            d.rsp.bresp = wr_ok ? `TR_RESP_OKAY : `TR_RESP_SLVERR;
        end
        if (I_AXI_REQ.awvalid && q.rsp.awready) begin
            d.aw_have = 1'b1;
            d.aw_addr = I_AXI_REQ.awaddr;
        end
        if (I_AXI_REQ.wvalid && q.rsp.wready) begin
            d.w_have = 1'b1;
            d.w_data = I_AXI_REQ.wdata;
            d.w_strb = I_AXI_REQ.wstrb;
        end
        d.rsp.awready = ~d.aw_have;
        d.rsp.wready = ~d.w_have;

        // Trace start and stop; a hardware overflow in the same cycle stays
        if (stop_cmd) begin
            d.running = 1'b0;
        end
        if (start_cmd) begin
            d.running = 1'b1;
            d.triggered = 1'b0;
            d.ts_ovf = ovf_now;
            d.frames = 16'h0;
            d.filt_cnt = 16'h0;
            d.post_cnt = 16'h0;
            d.wr_ptr = '0;
            d.loop_cnt = q.loop_load;
            d.cycles = 32'h0;
            d.time_cnt = 32'h0;
            d.ts = 16'h0;
            d.pre_cnt = 8'h00;
            d.st = 6'h00;
        end

        // Read channel
        ra = I_AXI_REQ.araddr;
        rd_ok = 1'b1;
        rd_data = 32'h0;
        if (ra[11:8] == `TR_ROW_PAGE) begin
            if (int'(ra[4]) < ROWS) begin
                unique case (ra[3:2])
                    2'd0: rd_data = q.val[ra[7:5]][ra[4]][31:0];
                    2'd1: rd_data = {16'h0, q.val[ra[7:5]][ra[4]][47:32]};
                    2'd2: rd_data = q.care[ra[7:5]][ra[4]][31:0];
                    2'd3: rd_data = {16'h0, q.care[ra[7:5]][ra[4]][47:32]};
                endcase
            end else begin
                rd_ok = 1'b0;
            end
        end else if (ra[11:10] == `TR_BUF_PAGE) begin
            if (int'(ra[9:3]) < DEPTH && ra[1:0] == 2'h0) begin
                rd_data = ra[2] ? q.tbuf[ra[9:3]][63:32]
                    : q.tbuf[ra[9:3]][31:0];
            end else begin
                rd_ok = 1'b0;
            end
        end else if (ra[11:6] == `TR_EXPR_PAGE &&
            ra[5:2] < 4'(`TR_EXPR_NUM) && ra[1:0] == 2'h0) begin
            rd_data = q.expr[ra[5:2]];
        end else begin
            case (ra)
                `TR_CTRL: rd_data[`TR_CTRL_PROBE] = q.probe_sel;
                `TR_STATUS: rd_data = {18'h0, q.st, 5'h0, q.ts_ovf,
                    q.running, q.triggered};
                `TR_TRIG_DELAY: rd_data = {16'h0, q.trig_delay};
                `TR_FILT_DELAY: rd_data = {16'h0, q.filter_delay};
                `TR_LOOP_LOAD: rd_data = {16'h0, q.loop_load};
                `TR_PRESCALE: rd_data = {24'h0, q.prescale};
                `TR_EV_ACTIVE: rd_data = {24'h0, q.ev_active};
                `TR_ROW_EN: rd_data = 32'(q.row_en);
                `TR_SETCLR: rd_data = {26'h0, q.setclr};
                `TR_FRAMES: rd_data = {16'h0, q.frames};
                `TR_LOOP_CNT: rd_data = {16'h0, q.loop_cnt};
                `TR_CYCLES: rd_data = q.cycles;
                `TR_TIME: rd_data = q.time_cnt;
                default: rd_ok = 1'b0;
            endcase
        end
        if (I_AXI_REQ.arvalid && q.rsp.arready) begin
            d.rsp.rvalid = 1'b1;
            d.rsp.rdata = rd_data;
            d.rsp.rresp = rd_ok ? `TR_RESP_OKAY : `TR_RESP_SLVERR;
        end else if (q.rsp.rvalid && I_AXI_REQ.rready) begin
            d.rsp.rvalid = 1'b0;
        end
        d.rsp.arready = ~d.rsp.rvalid;

        // Scope pin follows the pod term
        d.scope_n = ~d.st[`TR_S_POD];
    end

    // ==========================================================
    // Registers
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

    assign O_AXI_RSP = q.rsp;
    assign O_SCOPE_OUTPUT_PIN_N = q.scope_n;
endmodule

// ### tb/trace_monitor.sv
/* Port checker for the trace capture top.
   Assumes it is bound to the top and sees only its ports. */
`timescale 1ns/1ps
module trace_monitor #(
    parameter int ROWS = 2,
    parameter int DEPTH = 16
) (
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    input trace_pkg::target_pins_t I_TARGET_PINS,
    input trace_pkg::axi_lite_req_t I_AXI_REQ,
    input trace_pkg::axi_lite_rsp_t O_AXI_RSP,
    input wire logic O_SCOPE_OUTPUT_PIN_N
);
    import trace_pkg::*;
    axi_lite_req_t q;
    axi_lite_rsp_t s;
    logic quiet;
    assign q = I_AXI_REQ;
    assign s = O_AXI_RSP;
    assign quiet = I_TARGET_PINS.program_fetch_strobe_n & !q.wvalid
        & I_TARGET_PINS.read_strobe_n & I_TARGET_PINS.write_strobe_n;
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_NRST);
    // ==========================================================
    // Handshakes and scope pin
    sequence s_wtake; q.awvalid && s.awready && q.wvalid && s.wready;
    endsequence
    sequence s_wdone; !s.awready ##1 (s.awready && s.bvalid); endsequence
    property p_wresp; s_wtake |=> s_wdone; endproperty
    property p_wdrop; q.wvalid && s.wready |=> !s.wready; endproperty
    property p_bdone; s.bvalid && q.bready |=> !s.bvalid; endproperty
    property p_rresp; q.arvalid && s.arready |=> s.rvalid && !s.arready;
    endproperty
    property p_rdone; s.rvalid && q.rready |=> !s.rvalid && s.arready;
    endproperty
    property p_rerr; s.rvalid && s.rresp != 2'h0 |-> s.rdata == 32'h0;
    endproperty
    property p_bcode; s.bvalid |-> s.bresp == 2'h0 || s.bresp == 2'h2;
    endproperty
    property p_pin; quiet [*8] |=> $stable(O_SCOPE_OUTPUT_PIN_N);
    endproperty
    a_wresp: assert property (p_wresp) else $error("write answer late");
    a_wdrop: assert property (p_wdrop) else $error("wready kept");
    a_bdone: assert property (p_bdone) else $error("bvalid kept");
    a_rresp: assert property (p_rresp) else $error("read answer late");
    a_rdone: assert property (p_rdone) else $error("rvalid kept");
    a_rerr: assert property (p_rerr) else $error("error data not 0");
    a_bcode: assert property (p_bcode) else $error("bad bresp");
    a_pin: assert property (p_pin) else $error("pin moved idle");
endmodule
bind trace_capture_top trace_monitor #(.ROWS(ROWS), .DEPTH(DEPTH)) i_mon (
    .I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST),
    .I_TARGET_PINS(I_TARGET_PINS), .I_AXI_REQ(I_AXI_REQ),
    .O_AXI_RSP(O_AXI_RSP), .O_SCOPE_OUTPUT_PIN_N(O_SCOPE_OUTPUT_PIN_N));

// ### tb/target_bus_model.sv
/* Target bus model: one external memory cycle per call.
   Assumes calls start just after a rising clock edge. */
`timescale 1ns/1ps
module target_bus_model (
    input wire logic i_clk,
    output trace_pkg::target_pins_t o_pins
);
    import trace_pkg::*;
    // ==========================================================
    // Idle pins
    initial begin
        o_pins = '0;
        o_pins.program_fetch_strobe_n = '1;
        o_pins.read_strobe_n = '1;
        o_pins.write_strobe_n = '1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic cycle(input frame_t f, input int s);
        o_pins.ad_bus <= f.addr[7:0];
        o_pins.address_latch_strobe <= '1;
        hold(4);
        o_pins.address_latch_strobe <= '0;
        hold(5);
        o_pins.ad_bus <= ~f.addr[7:0];
        o_pins.addr_high <= f.addr[15:8];
        o_pins.port_three_probes <= {~f.port_three[7:6], f.port_three[5:0]};
        o_pins.external_probe_one <= f.port_three[7];
        o_pins.external_probe_zero <= f.port_three[6];
        o_pins.program_fetch_strobe_n <= s != 0;
        o_pins.read_strobe_n <= s != 1;
        o_pins.write_strobe_n <= s != 2;
        hold(5);
        o_pins.addr_high <= ~f.addr[15:8];
        o_pins.port_three_probes <= ~f.port_three;
        o_pins.external_probe_one <= ~f.port_three[7];
        o_pins.external_probe_zero <= ~f.port_three[6];
        o_pins.ad_bus <= f.data;
        o_pins.misc <= f.misc;
        o_pins.port_one_probes <= f.port_one;
        hold(5);
        o_pins.program_fetch_strobe_n <= '1;
        o_pins.read_strobe_n <= '1;
        o_pins.write_strobe_n <= '1;
        hold(3);
        o_pins.ad_bus <= ~f.data;
        o_pins.misc <= ~f.misc;
        o_pins.port_one_probes <= ~f.port_one;
        hold(10);
    endtask
endmodule

// ### tb/testbench.sv
/* Self-checking bench for the trace capture top.
   Assumes the target bus model file is compiled first. */
`timescale 1ns/1ps
module testbench;
    import trace_pkg::*;
    logic clk = '0;
    logic nrst = '0;
    logic pin_n;
    axi_lite_req_t req = '0;
    axi_lite_rsp_t rsp;
    target_pins_t pins;
    logic [65:0] exp_q[$];
    int fail_count = 0, comparisons = 0, cyc = 0, seed = 78731;
    frame_t f, g;
    trace_capture_top #(.ROWS(2), .DEPTH(16)) i_dut (.I_CORE_CLK(clk),
        .I_NRST(nrst), .I_TARGET_PINS(pins), .I_AXI_REQ(req),
        .O_AXI_RSP(rsp), .O_SCOPE_OUTPUT_PIN_N(pin_n));
    target_bus_model i_tgt (.i_clk(clk), .o_pins(pins));
    initial forever #4 clk = ~clk;
    // ==========================================================
    // Checking and closing
    task chk(input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) begin : watch
        logic [65:0] e;
        if (rsp.rvalid && req.rready) begin
            e = exp_q.pop_front();
            chk({rsp.rresp, rsp.rdata & e[65:34]}, e[33:0]);
        end
        if (rsp.bvalid && req.bready) begin
            e = exp_q.pop_front();
            chk({rsp.bresp, 32'h0}, e[33:0]);
        end
    end
    always @(posedge clk) if (++cyc == 20000) begin
        fail_count++;
        complete_run();
    end
    // ==========================================================
    // Bus master
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw, w;
        exp_q.push_back({32'h0, r, 32'h0});
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= '1;
        req.wvalid <= '1;
        aw = '1;
        w = '1;
        while (aw || w) begin
            @(posedge clk);
            if (aw && rsp.awready) begin aw = '0; req.awvalid <= '0; end
            if (w && rsp.wready) begin w = '0; req.wvalid <= '0; end
        end
        do @(posedge clk); while (!rsp.bvalid);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] m, input logic [33:0] e);
        exp_q.push_back({m, e});
        req.araddr <= a;
        req.arvalid <= '1;
        do @(posedge clk); while (!rsp.arready);
        req.arvalid <= '0;
        do @(posedge clk); while (!rsp.rvalid);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        req.bready <= '1;
        req.rready <= '1;
        repeat (5) @(posedge clk);
        nrst <= '1;
        @(posedge clk);
        rd(12'h008, 32'hffff, {2'h0, 32'h8000});
        rd(12'h034, '1, {2'h2, 32'h0});
        wr(12'h024, 32'h5, 2'h2);
        $display("reset test done");
        f = frame_t'(48'({$random(seed), $random(seed)}));
        wr(12'h100, f[31:0], 2'h0);
        wr(12'h104, {16'h0, f[47:32]}, 2'h0);
        wr(12'h108, '1, 2'h0);
        wr(12'h10c, 32'hffff, 2'h0);
        wr(12'h01c, 32'h1, 2'h0);
        wr(12'h018, 32'h1, 2'h0);
        wr(12'h058, 32'h1, 2'h0);
        wr(12'h05c, 32'h1, 2'h0);
        wr(12'h000, 32'h5, 2'h0);
        for (int k = 0; k < 7; k++) begin
            g = f;
            if (k inside {[1:5]}) g[8*k+3] = ~g[8*k+3];
            if (k == 6) begin
                wr(12'h108, 32'hffff_f7ff, 2'h0);
                g[11] = ~g[11];
            end
            i_tgt.cycle(g, k % 3);
            chk({33'h0, pin_n}, {33'h0, k inside {[1:5]}});
        end
        $display("event test done");
        rd(12'h024, '1, {2'h0, 32'h7});
        rd(12'h400, '1, {2'h0, f[31:0]});
        rd(12'h404, 32'hffff, {2'h0, 16'h0, f[47:32]});
        rd(12'h408, '1, {2'h0, f[31:0] ^ 32'h800});
        rd(12'h02c, '1, {2'h0, 32'h1});
        rd(12'h004, 32'h3f03, {2'h0, 32'h3002});
        @(posedge clk);
        $display("status test done");
        wr(12'h014, 32'h3, 2'h0);
        wr(12'h054, 32'h1, 2'h0);
        wr(12'h040, 32'h1, 2'h0);
        wr(12'h008, 32'h1, 2'h0);
        wr(12'h000, 32'h5, 2'h0);
        g[3] = ~f[3];
        for (int k = 0; k < 3; k++) begin
            i_tgt.cycle(k == 1 ? g : f, k);
        end
        rd(12'h024, '1, {2'h0, 32'h2});
        rd(12'h028, '1, {2'h0, 32'h1});
        rd(12'h004, 32'h3, {2'h0, 32'h1});
        $display("trigger test done");
        complete_run();
    end
endmodule
